// file: logic/idsj_exec.sv
// execution logic for decrement/increment skip and absolute jump instructions
`timescale 1ns/10ps
`default_nettype none
`include "idsj_cfg.svh"
module idsj_exec #(
	parameter int CNT_W = 21
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic next_is_two_word,
	input wire logic ext_set_en,
	input wire logic [3:0] bank_select_reg,
	input wire logic [11:0] fsr2_base,
	input wire logic [7:0] file_rdata,
	output logic [11:0] file_raddr,
	output logic instr_ack,
	output idsj_pkg::idsj_fwrite_t file_wr_q,
	output logic [7:0] accum_q,
	output logic accum_wr_q,
	output idsj_pkg::idsj_flags_t flags_q,
	output logic [CNT_W-1:0] program_counter_q,
	output logic jump_load_q,
	output logic idle_op_q,
	output logic discard_q
);
	import idsj_pkg::*;

	// only a 21-bit counter holds the 20-bit literal above a zero lsb
	if (CNT_W != 21) begin : g_cnt_w_check
		$error("program counter must be 21 bits");
	end

	// --------------------------------------------------
	// address formation
	// --------------------------------------------------
	function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
			input logic ext, input logic [3:0] bank_sel, input logic [11:0] base);
		logic [11:0] r;
		r = {bank_sel, f};
		if (!a) begin
			if (ext && f <= `IDSJ_IDX_LIMIT)
				r = 12'(base + {4'h0, f});
			else if (f < `IDSJ_ACC_SPLIT)
				r = {4'h0, f};
			else
				r = {`IDSJ_ACC_HIGH_BANK, f};
		end
		return r;
	endfunction

	idsj_state_t state_q;
	logic [7:0] jlow_q;
	logic jump_wait_q;
	logic [7:0] inc_v;
	logic [7:0] dec_v;
	logic [5:0] op6;
	logic is_decsz, is_decsnz, is_incr, is_incsz, is_jump1, skip, in_exec;

	// --------------------------------------------------
	// decode
	// --------------------------------------------------
	assign op6 = instr_word[15:10];
	assign in_exec = (state_q == ST_EXEC) && instr_valid;
	assign is_decsz = in_exec && op6 == `IDSJ_OP_DECSZ;
	assign is_decsnz = in_exec && op6 == `IDSJ_OP_DECSNZ;
	assign is_incr = in_exec && op6 == `IDSJ_OP_INCR;
	assign is_incsz = in_exec && op6 == `IDSJ_OP_INCSZ;
	assign is_jump1 = in_exec && instr_word[15:8] == `IDSJ_OP_JUMP1;
	assign file_raddr = eff_addr(instr_word[7:0], instr_word[8], ext_set_en,
			bank_select_reg, fsr2_base);
	assign inc_v = 8'(file_rdata + 8'h01);
	assign dec_v = 8'(file_rdata - 8'h01);
	// skip decision per opcode
	assign skip = (is_decsz && dec_v == 8'h00) ||
			(is_decsnz && dec_v != 8'h00) ||
			(is_incsz && inc_v == 8'h00);
	// handshake: one word taken per cycle while valid
	assign instr_ack = instr_valid;

	// --------------------------------------------------
	// sequencing
	// --------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= ST_EXEC;
		end else begin
			case (state_q)
				ST_EXEC: begin
					if (is_jump1)
						state_q <= ST_IDLE;
					else if (skip && next_is_two_word)
						state_q <= ST_SKIP2;
					else if (skip)
						state_q <= ST_IDLE;
				end
				ST_IDLE: begin
					if (instr_valid)
						state_q <= ST_EXEC;
				end
				ST_SKIP2: begin
					if (instr_valid)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_EXEC;
			endcase
		end
	end

	// low literal of the jump, held for the second word; the pending mark stops a
	// skipped two-word instruction whose second word looks alike from loading
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			jlow_q <= 8'h00;
			jump_wait_q <= 1'b0;
		end else if (is_jump1) begin
			jlow_q <= instr_word[7:0];
			jump_wait_q <= 1'b1;
		end else if (state_q == ST_IDLE && instr_valid) begin
			jump_wait_q <= 1'b0;
		end
	end

	// program counter load on second jump word; discarded words are idle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			program_counter_q <= '0;
			jump_load_q <= 1'b0;
			idle_op_q <= 1'b0;
			discard_q <= 1'b0;
		end else begin
			jump_load_q <= 1'b0;
			idle_op_q <= 1'b0;
			discard_q <= skip;
			if (state_q != ST_EXEC && instr_valid) begin
				idle_op_q <= 1'b1;
				if (instr_word[15:12] == `IDSJ_OP_JUMP2 && state_q == ST_IDLE &&
						jump_wait_q) begin
					program_counter_q <= {instr_word[11:0], jlow_q, 1'b0};
					jump_load_q <= 1'b1;
				end
			end
		end
	end

	// --------------------------------------------------
	// results
	// --------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			accum_q <= 8'h00;
			accum_wr_q <= 1'b0;
			file_wr_q <= '0;
		end else begin
			accum_wr_q <= 1'b0;
			file_wr_q.en <= 1'b0;
			if (is_decsz || is_decsnz || is_incr || is_incsz) begin
				if (instr_word[9]) begin
					file_wr_q.en <= 1'b1;
					file_wr_q.addr <= file_raddr;
					file_wr_q.data <= (is_decsz || is_decsnz) ? dec_v : inc_v;
				end else begin
					accum_wr_q <= 1'b1;
					accum_q <= (is_decsz || is_decsnz) ? dec_v : inc_v;
				end
			end
		end
	end

	// flags change only for increment_file; skip forms leave them alone
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flags_q <= '0;
		end else if (is_incr) begin
			flags_q.c <= file_rdata == 8'hff;
			flags_q.dc <= file_rdata[3:0] == 4'hf;
			flags_q.z <= inc_v == 8'h00;
			flags_q.ov <= file_rdata == 8'h7f;
			flags_q.n <= inc_v[7];
		end
	end

	// --------------------------------------------------
	// checks
	// --------------------------------------------------
	sequence jump_word_s;
		is_jump1;
	endsequence
	jump_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
			jump_word_s |=> state_q == ST_IDLE)
		else $error("jump did not enter idle cycle");
	decsz_skip_a: assert property (@(posedge clk_sys) disable iff (reset)
			is_decsz && file_rdata == 8'h01 && !next_is_two_word |=> state_q == ST_IDLE)
		else $error("zero decrement did not skip");
	decsnz_skip_a: assert property (@(posedge clk_sys) disable iff (reset)
			is_decsnz && file_rdata == 8'h01 |=> state_q == ST_EXEC)
		else $error("non-zero skip taken on zero");
	incsz_skip_a: assert property (@(posedge clk_sys) disable iff (reset)
			is_incsz && file_rdata == 8'hff && next_is_two_word |=> state_q == ST_SKIP2)
		else $error("increment skip over two words missed");
	incr_flags_a: assert property (@(posedge clk_sys) disable iff (reset)
			is_incr && file_rdata == 8'hff |=> flags_q.z && flags_q.c)
		else $error("increment flags wrong at wrap");
	skip_flags_a: assert property (@(posedge clk_sys) disable iff (reset)
			(is_decsz || is_incsz || is_decsnz) |=> $stable(flags_q))
		else $error("skip instruction changed flags");
	dest_file_a: assert property (@(posedge clk_sys) disable iff (reset)
			is_incsz && instr_word[9] |=> file_wr_q.en && !accum_wr_q)
		else $error("destination select wrong");
	access_bank_a: assert property (@(posedge clk_sys) disable iff (reset)
			in_exec && instr_word[8] |-> file_raddr[11:8] == bank_select_reg)
		else $error("bank select not used");
	indexed_a: assert property (@(posedge clk_sys) disable iff (reset)
			in_exec && !instr_word[8] && ext_set_en && instr_word[7:0] <= 8'h5f
			|-> file_raddr == 12'(fsr2_base + {4'h0, instr_word[7:0]}))
		else $error("indexed literal offset not applied");
	skip2_len_a: assert property (@(posedge clk_sys) disable iff (reset)
			state_q == ST_SKIP2 && instr_valid |=> state_q == ST_IDLE)
		else $error("three-cycle skip wrong");
	wrap_a: assert property (@(posedge clk_sys) disable iff (reset)
			is_incr && !instr_word[9] && file_rdata == 8'hff |=> accum_q == 8'h00)
		else $error("increment did not wrap");
	// a skipped two-word instruction passes both words without touching the counter
	sequence skipped_pair_s;
		state_q == ST_SKIP2 && instr_valid ##1 instr_valid;
	endsequence
	skip_noload_a: assert property (@(posedge clk_sys) disable iff (reset)
			skipped_pair_s |=> !jump_load_q)
		else $error("skipped jump word loaded the counter");
endmodule // idsj_exec
`default_nettype wire

// file: logic/idsj_cfg.svh
// opcode, address and bank constants for the inc/dec/skip/jump execution block
`ifndef IDSJ_CFG_SVH
`define IDSJ_CFG_SVH
`define IDSJ_OP_DECSZ 6'h0b
`define IDSJ_OP_DECSNZ 6'h13
`define IDSJ_OP_INCR 6'h0a
`define IDSJ_OP_INCSZ 6'h0f
`define IDSJ_OP_JUMP1 8'hef
`define IDSJ_OP_JUMP2 4'hf
`define IDSJ_IDX_LIMIT 8'h5f
`define IDSJ_ACC_SPLIT 8'h60
`define IDSJ_ACC_HIGH_BANK 4'hf
`endif

// file: logic/idsj_pkg.sv
// types for the inc/dec/skip/jump execution block
package idsj_pkg;
	typedef enum logic [2:0] {ST_EXEC, ST_IDLE, ST_SKIP2} idsj_state_t;
	// flag bits in order c, dc, z, ov, n
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} idsj_flags_t;
	// file register write request
	typedef struct packed {
		logic en;
		logic [11:0] addr;
		logic [7:0] data;
	} idsj_fwrite_t;
endpackage

// file: test/inc_dec_skip_jump_exec_tb.sv
// self-checking bench for the inc/dec/skip/jump execution block
`timescale 1ns/10ps
`default_nettype none
`include "idsj_cfg.svh"
module inc_dec_skip_jump_exec_tb;
	import idsj_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic next_is_two_word = 1'b0;
	logic ext_set_en = 1'b0;
	logic [3:0] bank_select_reg = 4'h3;
	logic [11:0] fsr2_base = 12'h200;
	logic [7:0] file_rdata = 8'h00;
	logic [11:0] file_raddr;
	logic instr_ack;
	idsj_fwrite_t file_wr_q;
	logic [7:0] accum_q;
	logic accum_wr_q;
	idsj_flags_t flags_q;
	logic [20:0] program_counter_q;
	logic jump_load_q;
	logic idle_op_q;
	logic discard_q;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	idsj_exec dut (.clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid),
		.instr_word(instr_word), .next_is_two_word(next_is_two_word),
		.ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg), .fsr2_base(fsr2_base),
		.file_rdata(file_rdata), .file_raddr(file_raddr), .instr_ack(instr_ack),
		.file_wr_q(file_wr_q), .accum_q(accum_q), .accum_wr_q(accum_wr_q), .flags_q(flags_q),
		.program_counter_q(program_counter_q), .jump_load_q(jump_load_q), .idle_op_q(idle_op_q),
		.discard_q(discard_q));
	// --------------------------------
	// clock and hang guard
	// --------------------------------
	always #20 clk_sys = ~clk_sys;
	// the run needs well under a hundred cycles, so a hang ends fast
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			summarize();
		end
	end
	// --------------------------------
	// shared tasks
	// --------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one executed word; effective address checked while it is presented
	task automatic issue(input logic [5:0] o, input logic d, input logic a, input logic [7:0] f,
		input logic [7:0] rd, input logic [11:0] ea);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_word <= {o, d, a, f};
		file_rdata <= rd;
		@(negedge clk_sys);
		chk("file_raddr", 32'(ea), 32'(file_raddr));
		chk("instr_ack", 32'h1, 32'(instr_ack));
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		next_is_two_word <= 1'b0;
		@(negedge clk_sys);
	endtask
	// two words back to back, results of the second seen on return
	task automatic words(input logic [15:0] w1, input logic [15:0] w2);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_word <= w1;
		@(posedge clk_sys);
		instr_word <= w2;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_incr();
		issue(`IDSJ_OP_INCR, 1'b0, 1'b1, 8'hff, 8'hff, 12'h3ff);
		chk("accum_q", 32'h0, 32'(accum_q));
		chk("accum_wr_q", 32'h1, 32'(accum_wr_q));
		chk("flags_q", 32'h07, 32'(flags_q));
		chk("discard_q", 32'h0, 32'(discard_q));
		$display("increment done");
	endtask
	task automatic t_decsz();
		@(posedge clk_sys);
		ext_set_en <= 1'b1;
		issue(`IDSJ_OP_DECSZ, 1'b1, 1'b0, 8'h60, 8'h01, 12'hf60);
		chk("file_wr_q", 32'(21'h1f6000), 32'(file_wr_q));
		chk("discard_q", 32'h1, 32'(discard_q));
		chk("flags_q", 32'h07, 32'(flags_q));
		words(16'h0000, 16'h0000);
		$display("decsz done");
	endtask
	task automatic t_decsnz();
		issue(`IDSJ_OP_DECSNZ, 1'b0, 1'b0, 8'h5f, 8'h05, 12'h25f);
		chk("accum_q", 32'h04, 32'(accum_q));
		chk("discard_q", 32'h1, 32'(discard_q));
		words(16'h0000, 16'h0000);
		issue(`IDSJ_OP_DECSNZ, 1'b0, 1'b0, 8'h5f, 8'h01, 12'h25f);
		chk("discard_q", 32'h0, 32'(discard_q));
		chk("flags_q", 32'h07, 32'(flags_q));
		$display("decsnz done");
	endtask
	task automatic t_incsz();
		@(posedge clk_sys);
		ext_set_en <= 1'b0;
		next_is_two_word <= 1'b1;
		issue(`IDSJ_OP_INCSZ, 1'b1, 1'b0, 8'h10, 8'hff, 12'h010);
		chk("file_wr_q", 32'(21'h101000), 32'(file_wr_q));
		chk("discard_q", 32'h1, 32'(discard_q));
		words(16'hef12, 16'hf345);
		chk("idle_op_q", 32'h1, 32'(idle_op_q));
		chk("jump_load_q", 32'h0, 32'(jump_load_q));
		$display("incsz done");
	endtask
	task automatic t_jump();
		words(16'hef12, 16'hf345);
		chk("program_counter_q", 32'h68a24, 32'(program_counter_q));
		chk("jump_load_q", 32'h1, 32'(jump_load_q));
		chk("idle_op_q", 32'h1, 32'(idle_op_q));
		chk("flags_q", 32'h07, 32'(flags_q));
		$display("jump done");
	endtask
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		t_incr();
		t_decsz();
		t_decsnz();
		t_incsz();
		t_jump();
		summarize();
	end
endmodule // inc_dec_skip_jump_exec_tb
`default_nettype wire
